/* rcg_divider.sv */
// Purpose: divides a sampled source level by twice a divide value
// Assumes: source is a level sampled on CLK, slower than half of CLK
// Notes:   boundary marks a point where the ratio may change glitch-free
`timescale 1ns/1ps
module rcg_divider
    import rcg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        run,
    input  wire logic        src,
    input  wire logic [14:0] div_val,
    // result
    output logic             clk_out,
    output logic             boundary
);

    rcg_div_s st_q;
    rcg_div_s st_d;
    logic     rise;

    assign rise = src & ~st_q.src_prev;

    always_comb begin
        st_d          = st_q;
        st_d.src_prev = src;
        boundary      = 1'b0;
        if (!run) begin
            st_d.count   = '0;
            st_d.clk_out = 1'b0;
            boundary     = 1'b1;
        end else if (div_val == RCG_DIV_BYPASS) begin
            st_d.count   = '0;
            st_d.clk_out = src;
            boundary     = 1'b1;
        end else if (rise) begin
            if (st_q.count >= div_val - 15'h0001) begin
                st_d.count   = '0;
                st_d.clk_out = ~st_q.clk_out;
                // switch only after a full high+low pair
                boundary     = st_q.clk_out;
            end else begin
                st_d.count = st_q.count + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign clk_out = st_q.clk_out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pass_through: assert property (
        run && div_val == RCG_DIV_BYPASS |=> clk_out == $past(src))
        else $error("bypass output does not follow source");

    a_toggle_on_wrap: assert property (
        run && div_val != RCG_DIV_BYPASS && rise && st_q.count == div_val - 15'h0001
        |=> clk_out != $past(clk_out))
        else $error("divider missed its toggle");

    a_hold_between: assert property (
        run && div_val != RCG_DIV_BYPASS && !rise |=> $stable(clk_out))
        else $error("divider toggled without a source edge");

endmodule

/* rcg_pkg.sv */
// Purpose: shared constants and types for the reference clock generator
// Assumes: one 32-bit control word on an APB slave
// Notes:   field positions follow the control word layout
package rcg_pkg;

    // register map
    localparam logic [11:0] RCG_CTRL_OFFSET   = 12'h000;
    localparam logic [31:0] RCG_CTRL_RESET    = 32'h0000_0000;

    // control word field positions
    localparam int          RCG_DIV_LSB       = 16;
    localparam int          RCG_DIV_W         = 15;
    localparam int          RCG_ON_BIT        = 15;
    localparam int          RCG_STOP_IN_IDLE_BIT      = 13;
    localparam int          RCG_OE_BIT        = 12;
    localparam int          RCG_RUN_IN_SLEEP_BIT      = 11;
    localparam int          RCG_SW_BIT        = 9;
    localparam int          RCG_ACT_BIT       = 8;
    localparam int          RCG_SEL_LSB       = 0;
    localparam int          RCG_SEL_W         = 4;

    // sources whose selection makes run-in-sleep meaningless
    localparam logic [3:0]  RCG_SEL_SYS       = 4'h0;
    localparam logic [3:0]  RCG_SEL_PBUS      = 4'h1;

    localparam logic [14:0] RCG_DIV_BYPASS    = 15'h0000;

    typedef struct packed {
        logic [14:0] divide_value;
        logic        on;
        logic        stop_in_idle;
        logic        out_en;
        logic        run_in_sleep;
        logic        divider_switch;
        logic [3:0]  source_select;
    } rcg_ctrl_s;

    typedef struct packed {
        rcg_ctrl_s   ctrl;
        logic [14:0] div_act;
        logic [3:0]  sel_act;
        logic [31:0] prdata;
    } rcg_state_s;

    typedef struct packed {
        logic [14:0] count;
        logic        src_prev;
        logic        clk_out;
    } rcg_div_s;

endpackage

/* rcg_top.sv */
// Purpose: reference clock generator with APB control word
// Assumes: source levels and power-mode inputs synchronous to CLK
// Notes:   zero-wait APB slave; read data captured in the setup cycle
//
// Summary of operation
// - fifteen-bit divide value in bits 30..16 sets the source division
// - bit 15 enables the generator; zero holds it disabled
// - stop-in-idle bit 13 halts the generator while the chip idles
// - output-enable bit 12 drives the reference clock onto its pin
// - run-in-sleep bit 11 keeps the output running during sleep
// - run-in-sleep ignored when source select is 0000 or 0001
// - bit 9 reads one while a divider change is pending
// - while enabled, new divider and source take effect only on switch
// - read-only bit 8 shows whether a clock request is active
// - bits 31, 14, 10 and 7..4 read as zero
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rcg_top
    import rcg_pkg::*;
#(
    parameter int NSRC   = 16,
    parameter int ADDR_W = 12
)(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // clock sources and power modes
    input  wire logic [NSRC-1:0]   SRC_CLK,
    input  wire logic              IDLE_MODE,
    input  wire logic              SLEEP_MODE,
    // reference output pin and internal copy
    output logic                   REF_CLK,
    output logic                   REFERENCE_OUTPUT_PIN_O,
    output logic                   REFERENCE_OUTPUT_PIN_OE
);

    rcg_state_s  st_q;
    rcg_state_s  st_d;
    logic        hit;
    logic        wr_acc;
    logic        setup;
    logic        idle_halt;
    logic        sleep_halt;
    logic        run;
    logic        src_lvl;
    logic        boundary;
    logic        ref_q;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    assign hit    = PADDR == RCG_CTRL_OFFSET[ADDR_W-1:0];
    assign setup  = PSEL & ~PENABLE;
    assign wr_acc = PSEL & PENABLE & PWRITE & hit;

    // no wait states; a miss answers with an error and zero data
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit;
    assign PRDATA  = st_q.prdata;

    ////////////////////////////////////////////////////////////////////
    // run conditions

    assign idle_halt = IDLE_MODE & st_q.ctrl.stop_in_idle;

    // the system and bus sources stop in sleep anyway, so the bit is moot
    always_comb begin
        if (st_q.sel_act == RCG_SEL_SYS || st_q.sel_act == RCG_SEL_PBUS) begin
            sleep_halt = SLEEP_MODE;
        end else begin
            sleep_halt = SLEEP_MODE & ~st_q.ctrl.run_in_sleep;
        end
    end

    assign run = st_q.ctrl.on & ~idle_halt & ~sleep_halt;

    // out-of-range select reads as a silent source
    always_comb begin
        if (int'(st_q.sel_act) < NSRC) begin
            src_lvl = SRC_CLK[st_q.sel_act];
        end else begin
            src_lvl = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // readback word

    always_comb begin
        rd_word                                    = '0;
        rd_word[RCG_DIV_LSB +: RCG_DIV_W]          = st_q.ctrl.divide_value;
        rd_word[RCG_ON_BIT]                        = st_q.ctrl.on;
        rd_word[RCG_STOP_IN_IDLE_BIT]                      = st_q.ctrl.stop_in_idle;
        rd_word[RCG_OE_BIT]                        = st_q.ctrl.out_en;
        rd_word[RCG_RUN_IN_SLEEP_BIT]                      = st_q.ctrl.run_in_sleep;
        rd_word[RCG_SW_BIT]                        = st_q.ctrl.divider_switch;
        rd_word[RCG_ACT_BIT]                       = run;
        rd_word[RCG_SEL_LSB +: RCG_SEL_W]          = st_q.ctrl.source_select;
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_d = st_q;

        if (setup) begin
            st_d.prdata = hit && !PWRITE ? rd_word : 32'h0000_0000;
        end

        if (wr_acc) begin
            st_d.ctrl.divide_value  = PWDATA[RCG_DIV_LSB +: RCG_DIV_W];
            st_d.ctrl.on            = PWDATA[RCG_ON_BIT];
            st_d.ctrl.stop_in_idle  = PWDATA[RCG_STOP_IN_IDLE_BIT];
            st_d.ctrl.out_en        = PWDATA[RCG_OE_BIT];
            st_d.ctrl.run_in_sleep  = PWDATA[RCG_RUN_IN_SLEEP_BIT];
            st_d.ctrl.source_select = PWDATA[RCG_SEL_LSB +: RCG_SEL_W];
            // writing zero leaves a pending switch alone
            st_d.ctrl.divider_switch = st_q.ctrl.divider_switch
                                       | PWDATA[RCG_SW_BIT];
        end

        if (!st_q.ctrl.on) begin
            // disabled: new ratio applies at once, switch has nothing to wait for
            st_d.div_act = st_q.ctrl.divide_value;
            st_d.sel_act = st_q.ctrl.source_select;
            if (!(wr_acc && PWDATA[RCG_SW_BIT])) begin
                st_d.ctrl.divider_switch = 1'b0;
            end
        end else if (st_q.ctrl.divider_switch && boundary) begin
            // load at a cycle boundary so the pin never sees a runt pulse
            st_d.div_act = st_q.ctrl.divide_value;
            st_d.sel_act = st_q.ctrl.source_select;
            // a fresh set in the same cycle wins over the completion
            if (!(wr_acc && PWDATA[RCG_SW_BIT])) begin
                st_d.ctrl.divider_switch = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            // reset word is in bus layout, not struct layout, so take it field by field
            st_q                     <= '0;
            st_q.ctrl.divide_value   <= RCG_CTRL_RESET[RCG_DIV_LSB +: RCG_DIV_W];
            st_q.ctrl.on             <= RCG_CTRL_RESET[RCG_ON_BIT];
            st_q.ctrl.stop_in_idle   <= RCG_CTRL_RESET[RCG_STOP_IN_IDLE_BIT];
            st_q.ctrl.out_en         <= RCG_CTRL_RESET[RCG_OE_BIT];
            st_q.ctrl.run_in_sleep   <= RCG_CTRL_RESET[RCG_RUN_IN_SLEEP_BIT];
            st_q.ctrl.divider_switch <= RCG_CTRL_RESET[RCG_SW_BIT];
            st_q.ctrl.source_select  <= RCG_CTRL_RESET[RCG_SEL_LSB +: RCG_SEL_W];
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // divider and pin

    rcg_divider u_div (
        .clk      (CLK),
        .rst_n    (RESET_N),
        .run      (run),
        .src      (src_lvl),
        .div_val  (st_q.div_act),
        .clk_out  (ref_q),
        .boundary (boundary)
    );

    assign REF_CLK                 = ref_q;
    assign REFERENCE_OUTPUT_PIN_O  = ref_q & st_q.ctrl.out_en;
    assign REFERENCE_OUTPUT_PIN_OE = st_q.ctrl.on & st_q.ctrl.out_en;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_switch_req;
        st_q.ctrl.on && st_q.ctrl.divider_switch;
    endsequence

    sequence s_switch_done;
        st_q.div_act == $past(st_q.ctrl.divide_value)
        && st_q.sel_act == $past(st_q.ctrl.source_select);
    endsequence

    a_switch_loads: assert property (
        s_switch_req and boundary |=> s_switch_done)
        else $error("pending ratio not loaded at boundary");

    a_ratio_held: assert property (
        st_q.ctrl.on && $past(st_q.ctrl.on) && !$past(st_q.ctrl.divider_switch)
        |-> $stable(st_q.div_act) && $stable(st_q.sel_act))
        else $error("active ratio changed without a switch");

    a_switch_clears: assert property (
        s_switch_req and boundary and !wr_acc |=> !st_q.ctrl.divider_switch)
        else $error("switch flag stayed set after load");

    a_off_quiet: assert property (
        !st_q.ctrl.on |=> !REF_CLK)
        else $error("reference runs while disabled");

    a_idle_stop: assert property (
        st_q.ctrl.stop_in_idle && IDLE_MODE |=> !REF_CLK)
        else $error("reference runs in idle with stop set");

    a_sleep_stop: assert property (
        SLEEP_MODE && !st_q.ctrl.run_in_sleep |=> !REF_CLK)
        else $error("reference runs in sleep without run bit");

    a_sleep_moot: assert property (
        SLEEP_MODE && st_q.sel_act <= RCG_SEL_PBUS |=> !REF_CLK)
        else $error("core-clock source kept running in sleep");

    a_pin_gate: assert property (
        !st_q.ctrl.out_en |-> !REFERENCE_OUTPUT_PIN_OE && !REFERENCE_OUTPUT_PIN_O)
        else $error("pin driven with output disabled");

    a_status_read: assert property (
        setup && hit && !PWRITE |=> PRDATA[RCG_ACT_BIT] == $past(run))
        else $error("request status misreported");

    a_rsv_zero: assert property (
        PSEL && PENABLE |-> PRDATA[31] == 1'b0 && PRDATA[14] == 1'b0
                            && PRDATA[10] == 1'b0 && PRDATA[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

    ////////////////////////////////////////////////////////////////////
    // stored fields, readback, run conditions, pin and switch handling

    sequence s_read_setup;
        setup && hit && !PWRITE;
    endsequence

    sequence s_switch_write;
        wr_acc && PWDATA[RCG_SW_BIT];
    endsequence

    a_div_stored: assert property (
        wr_acc |=> st_q.ctrl.divide_value == $past(PWDATA[RCG_DIV_LSB +: RCG_DIV_W]))
        else $error("written divide value not stored");

    a_on_stored: assert property (
        wr_acc |=> st_q.ctrl.on == $past(PWDATA[RCG_ON_BIT]))
        else $error("written enable not stored");

    a_stop_in_idle_stored: assert property (
        wr_acc |=> st_q.ctrl.stop_in_idle == $past(PWDATA[RCG_STOP_IN_IDLE_BIT]))
        else $error("written stop-in-idle not stored");

    a_oe_stored: assert property (
        wr_acc |=> st_q.ctrl.out_en == $past(PWDATA[RCG_OE_BIT]))
        else $error("written output enable not stored");

    a_run_in_sleep_stored: assert property (
        wr_acc |=> st_q.ctrl.run_in_sleep == $past(PWDATA[RCG_RUN_IN_SLEEP_BIT]))
        else $error("written run-in-sleep not stored");

    a_sel_stored: assert property (
        wr_acc |=> st_q.ctrl.source_select == $past(PWDATA[RCG_SEL_LSB +: RCG_SEL_W]))
        else $error("written source select not stored");

    a_miss_ignored: assert property (
        PSEL && PENABLE && PWRITE && !hit
        |=> $stable(st_q.ctrl.divide_value) && $stable(st_q.ctrl.source_select)
            && $stable(st_q.ctrl.on))
        else $error("unmapped write changed the control word");

    a_miss_zero: assert property (
        setup && !hit |=> PRDATA == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_read_div: assert property (
        s_read_setup |=> PRDATA[RCG_DIV_LSB +: RCG_DIV_W] == $past(st_q.ctrl.divide_value))
        else $error("divide value misread");

    a_read_on: assert property (
        s_read_setup |=> PRDATA[RCG_ON_BIT] == $past(st_q.ctrl.on))
        else $error("enable misread");

    a_read_stop_in_idle: assert property (
        s_read_setup |=> PRDATA[RCG_STOP_IN_IDLE_BIT] == $past(st_q.ctrl.stop_in_idle))
        else $error("stop-in-idle misread");

    a_read_run_in_sleep: assert property (
        s_read_setup |=> PRDATA[RCG_RUN_IN_SLEEP_BIT] == $past(st_q.ctrl.run_in_sleep))
        else $error("run-in-sleep misread");

    a_read_switch: assert property (
        s_read_setup |=> PRDATA[RCG_SW_BIT] == $past(st_q.ctrl.divider_switch))
        else $error("switch flag misread");

    a_read_sel: assert property (
        s_read_setup |=> PRDATA[RCG_SEL_LSB +: RCG_SEL_W] == $past(st_q.ctrl.source_select))
        else $error("source select misread");

    a_on_runs: assert property (
        st_q.ctrl.on && !IDLE_MODE && !SLEEP_MODE |-> run)
        else $error("enabled generator not running");

    a_idle_continues: assert property (
        st_q.ctrl.on && !st_q.ctrl.stop_in_idle && !SLEEP_MODE |-> run)
        else $error("generator stopped in idle without stop bit");

    a_sleep_runs: assert property (
        st_q.ctrl.on && st_q.ctrl.run_in_sleep && SLEEP_MODE && !idle_halt
        && st_q.sel_act > RCG_SEL_PBUS |-> run)
        else $error("generator stopped in sleep with run bit set");

    a_pin_follows: assert property (
        st_q.ctrl.on && st_q.ctrl.out_en
        |-> REFERENCE_OUTPUT_PIN_OE && REFERENCE_OUTPUT_PIN_O == REF_CLK)
        else $error("pin not driven with output enabled");

    a_switch_sets: assert property (
        s_switch_write |=> st_q.ctrl.divider_switch)
        else $error("switch request not flagged");

    a_switch_waits: assert property (
        s_switch_req and !boundary |=> st_q.ctrl.divider_switch)
        else $error("switch flag dropped before a boundary");

    a_off_clears: assert property (
        !st_q.ctrl.on && !(wr_acc && PWDATA[RCG_SW_BIT]) |=> !st_q.ctrl.divider_switch)
        else $error("switch flag pending while disabled");

    a_off_applies: assert property (
        !st_q.ctrl.on |=> s_switch_done)
        else $error("disabled generator did not take the new ratio");

    a_write_held: assert property (
        st_q.ctrl.on && !st_q.ctrl.divider_switch && wr_acc
        |=> $stable(st_q.div_act) && $stable(st_q.sel_act))
        else $error("ratio applied on write without switch");

endmodule

/* rcg_top_tb.sv */
// Purpose: self-checking bench for the reference clock generator
// Assumes: zero-wait APB slave, all source lanes share one slow clock
// Notes:   reference edges are counted over windows of whole output periods
`timescale 1ns/1ps
module rcg_top_tb;
    import rcg_pkg::*;
    logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdata, seed, w;
    logic [15:0] SRC_CLK;
    logic        IDLE_MODE, SLEEP_MODE, REF_CLK, PIN_O, PIN_OE, rerr, src_run;
    logic [1:0]  src_cnt;
    logic [7:0]  cs;
    int          failures, checked, rises, pin_bad, n;
    logic [7:0]  cases [6] = '{8'hA2, 8'h2A, 8'h12, 8'h5A, 8'h51, 8'h50};

    rcg_top rcg_top_inst (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SRC_CLK(SRC_CLK), .IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE),
        .REF_CLK(REF_CLK), .REFERENCE_OUTPUT_PIN_O(PIN_O), .REFERENCE_OUTPUT_PIN_OE(PIN_OE));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // source: half period of four clocks, all lanes alike so any select has a source
    always @(posedge CLK) begin
        if (src_run) begin
            src_cnt <= src_cnt + 2'd1;
            if (src_cnt == 2'd3) begin
                SRC_CLK <= ~SRC_CLK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // fl holds enable, stop in idle, output enable, run in sleep
    function automatic logic [31:0] mk(input logic [14:0] dv, input logic [3:0] fl,
                                       input logic [3:0] sel);
        return (32'(dv) << RCG_DIV_LSB) | (32'(fl[3]) << RCG_ON_BIT)
             | (32'(fl[2]) << RCG_STOP_IN_IDLE_BIT) | (32'(fl[1]) << RCG_OE_BIT)
             | (32'(fl[0]) << RCG_RUN_IN_SLEEP_BIT) | 32'(sel);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int k;
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= addr;
        PWDATA  <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (PREADY !== 1'b1) begin
            failures++;
            close_out();
        end
        rdata = PRDATA;
        rerr = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // settle first, then count rises and watch the pin against the copy
    task automatic count(input logic en_oe);
        logic prev;
        repeat (40) @(negedge CLK);
        rises = 0;
        pin_bad = 0;
        prev = REF_CLK;
        repeat (192) begin
            @(negedge CLK);
            if (REF_CLK === 1'b1 && prev === 1'b0) rises++;
            if (PIN_O !== (REF_CLK & en_oe) || PIN_OE !== en_oe) pin_bad++;
            prev = REF_CLK;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {RESET_N, PSEL, PENABLE, PWRITE, IDLE_MODE, SLEEP_MODE} = '0;
        {PADDR, PWDATA, SRC_CLK, src_cnt} = '0;
        src_run = 1'b1;
        seed = 32'd21;
        failures = 0;
        checked = 0;
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        apb(0, RCG_CTRL_OFFSET, 0);
        chk(rdata, RCG_CTRL_RESET);
        for (int i = 0; i < 8; i++) begin
            w = xs() & ~32'h0000_8200;
            apb(1, RCG_CTRL_OFFSET, w);
            apb(0, RCG_CTRL_OFFSET, 0);
            chk(rdata, w & 32'h7FFF_380F);
        end
        apb(1, 12'h004, 32'hFFFF_FFFF);
        chk(32'(rerr), 1);
        apb(0, 12'h004, 0);
        chk(rdata, 0);
        apb(0, RCG_CTRL_OFFSET, 0);
        chk(rdata, w & 32'h7FFF_380F);
        // divide value two, source over four, output on the pin
        apb(1, RCG_CTRL_OFFSET, mk(2, 4'b0010, 2));
        count(1'b0);
        chk(32'(rises), 0);
        apb(1, RCG_CTRL_OFFSET, mk(2, 4'b1010, 2));
        count(1'b1);
        chk(32'(rises), 6);
        chk(32'(pin_bad), 0);
        apb(0, RCG_CTRL_OFFSET, 0);
        chk(rdata, mk(2, 4'b1010, 2) | 32'h100);
        apb(1, RCG_CTRL_OFFSET, mk(2, 4'b1000, 2));
        count(1'b0);
        chk(32'(pin_bad), 0);
        // power modes: {stop in idle, run in sleep, idle, sleep, runs, select}
        foreach (cases[j]) begin
            cs = cases[j];
            // fields change only while the request is off
            w = mk(2, {1'b0, cs[7], 1'b1, cs[6]}, {2'b0, cs[1:0]});
            apb(1, RCG_CTRL_OFFSET, w);
            apb(1, RCG_CTRL_OFFSET, w | 32'h0000_8000);
            @(posedge CLK);
            IDLE_MODE  <= cs[5];
            SLEEP_MODE <= cs[4];
            count(1'b1);
            chk(32'(rises), cs[3] ? 6 : 0);
            apb(0, RCG_CTRL_OFFSET, 0);
            chk(32'(rdata[RCG_ACT_BIT]), 32'(cs[3]));
            @(posedge CLK);
            IDLE_MODE  <= 1'b0;
            SLEEP_MODE <= 1'b0;
            apb(1, RCG_CTRL_OFFSET, w);
        end
        // new ratio held back until the switch is asked for; idle keeps the request quiet
        apb(1, RCG_CTRL_OFFSET, mk(2, 4'b0010, 2));
        apb(1, RCG_CTRL_OFFSET, mk(2, 4'b1110, 2));
        @(posedge CLK);
        IDLE_MODE <= 1'b1;
        apb(1, RCG_CTRL_OFFSET, mk(3, 4'b1110, 2));
        apb(0, RCG_CTRL_OFFSET, 0);
        chk(32'(rdata[RCG_ACT_BIT]), 0);
        chk(32'(rdata[30:16]), 3);
        @(posedge CLK);
        IDLE_MODE <= 1'b0;
        count(1'b1);
        chk(32'(rises), 6);
        // frozen source keeps the divider off its boundary, so the flag must stay up
        @(posedge CLK);
        src_run <= 1'b0;
        apb(1, RCG_CTRL_OFFSET, mk(3, 4'b1010, 2) | 32'h200);
        apb(0, RCG_CTRL_OFFSET, 0);
        chk(32'(rdata[RCG_SW_BIT]), 1);
        src_run <= 1'b1;
        n = 0;
        do begin
            apb(0, RCG_CTRL_OFFSET, 0);
            n++;
        end while (rdata[RCG_SW_BIT] !== 1'b0 && n < 100);
        chk(32'(rdata[RCG_SW_BIT]), 0);
        if (rdata[RCG_SW_BIT] !== 1'b0) close_out();
        count(1'b1);
        chk(32'(rises), 4);
        // zero divide passes the source straight through
        apb(1, RCG_CTRL_OFFSET, mk(3, 4'b0010, 2));
        apb(1, RCG_CTRL_OFFSET, mk(0, 4'b0010, 2));
        apb(1, RCG_CTRL_OFFSET, mk(0, 4'b1010, 2));
        count(1'b1);
        chk(32'(rises), 24);
        close_out();
    end
endmodule
